/* File: irt_pkg.sv */
// Package: constants and carrier types for the four-destination interrupt router
package irt_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_SRC  = 26;
   localparam int NUM_DST  = 4;
   localparam int NUM_EXT  = 2;
   localparam int TRIG_W   = 2;

   // ************************************************************
   // Source bit positions
   // ************************************************************
   localparam int SRC_PORT_AGG   = 0;
   localparam int SRC_EXT_ZERO   = 1;
   localparam int SRC_EXT_ONE    = 2;
   localparam int SRC_TIMER_ZERO = 3;
   localparam int SRC_TIMER_ONE  = 4;
   localparam int SRC_TIMER_TWO  = 5;
   localparam int SRC_SERIAL0    = 6;
   localparam int SRC_SERIAL1    = 7;
   localparam int SRC_TWO_WIRE0  = 8;
   localparam int SRC_TWO_WIRE1  = 9;
   localparam int SRC_SER_MASTER = 10;
   localparam int SRC_MAILBOX0   = 11;
   localparam int SRC_MAILBOX1   = 12;
   localparam int SRC_SERIAL_PIN = 13;
   localparam int SRC_PAR_PIN    = 14;
   localparam int SRC_MGMT0      = 15;
   localparam int SRC_MGMT1      = 16;
   localparam int SRC_FRAME_DMA  = 17;
   localparam int SRC_ANALYZER   = 18;
   localparam int SRC_TS_READY   = 19;
   localparam int SRC_TIME_SYNC  = 20;
   localparam int SRC_MEM_INTEG  = 21;
   localparam int SRC_EXTRACT    = 22;
   localparam int SRC_INJECT     = 23;
   localparam int SRC_PCIE       = 24;
   localparam int SRC_OAM        = 25;

   // Destination indices: two CPU lines, two off-chip
   localparam int DST_CPU_ZERO = 0;
   localparam int DST_CPU_ONE  = 1;
   localparam int DST_EXT_ZERO = 2;
   localparam int DST_EXT_ONE  = 3;

   // ************************************************************
   // Trigger encodings and reset values
   // ************************************************************
   typedef enum logic [1:0] {
      TRIG_LEVEL,
      TRIG_ANY_EDGE,
      TRIG_FALLING,
      TRIG_RISING
   } irt_trig_t;

   localparam logic RESET_BIT = 1'h0;

   // Peripheral sources grouped (bits 3..25), aggregate and ext fed inside
   typedef struct packed {
      logic oamEngineIrq;
      logic pcieIrq;
      logic injectionReadyIrq;
      logic extractionReadyIrq;
      logic memoryIntegrityIrq;
      logic timeSyncIrq;
      logic timestampReadyIrq;
      logic analyzerIrq;
      logic frameDmaIrq;
      logic mgmtCtrlOneIrq;
      logic mgmtCtrlZeroIrq;
      logic parallelPinIrq;
      logic serialPinIrq;
      logic mailboxSoftIrqOne;
      logic mailboxSoftIrqZero;
      logic serialMasterIrq;
      logic secondTwoWireIrq;
      logic twoWireIrq;
      logic secondSerialPortIrq;
      logic serialPortIrq;
      logic timerTwoIrq;
      logic timerOneIrq;
      logic timerZeroIrq;
   } irt_periph_t;

   // Output pin of an external destination: level plus enable
   typedef struct packed {
      logic level;
      logic enable;
   } irt_pin_t;

endpackage

/* File: irt_router.sv */
// Interrupt router: source logging, module aggregation, four destinations
//
// Contract
// - Route sources to exactly four destinations
// - Aggregate at 0, external inputs 1, 2
// - Timers zero to two at 3 to 5
// - Serial ports 6,7; two-wire 8,9
// - Serial master 10, mailbox 11 and 12
// - Serial pin 13, parallel 14, mgmt 15,16
// - DMA 17, analyzer 18, timestamp 19, sync 20
// - Integrity 21, extract 22, inject 23, 24, 25
// - Aggregate active when any module active enabled
// - Same bit position in every register
// - Raw view shows live source levels
// - Trigger select picks level or edge logging
// - Force injects event like a hardware source
// - Enable clear drops bits written one
// - Enable set raises bits written one
// - Active view shows enabled interrupting sources
// - Per-destination mask gates which sources propagate
// - Destination view: enabled, mapped, interrupting sources
// - Module inputs polarity corrected before raw
// - Module level has full control set; here force is tied off and enable is a plain mask
// - External inputs polarity corrected to active high
// - External outputs get polarity and drive mode
// - Level, any edge, falling, rising encodings
// - Write one clears; new event wins
// - Bypass uses raw, ignores log and trigger
// - Internal events all active high
`timescale 1ns/1ps

// ************************************************************
// Generic sticky logging stage, used for sources and modules
// ************************************************************
module irt_log_stage #(
   parameter int W = 26
) (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   // Live active-high levels
   input  wire logic [W-1:0]        rawIn,
   // Configuration
   input  wire logic [W-1:0][1:0]   trigSel,
   input  wire logic [W-1:0]        bypass,
   input  wire logic [W-1:0]        force_,
   input  wire logic [W-1:0]        logClear,
   input  wire logic [W-1:0]        enable,
   // Results
   output logic [W-1:0]             eventLog,
   output logic [W-1:0]             activeView
);
   logic [W-1:0] prev_reg;
   logic [W-1:0] log_reg;
   logic [W-1:0] log_next;
   logic [W-1:0] hit;

   // Per-bit trigger detection and sticky update
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic rise;
      logic fall;
      assign rise = rawIn[i] & ~prev_reg[i];
      assign fall = ~rawIn[i] & prev_reg[i];
      assign hit[i] =
         (trigSel[i] == 2'(irt_pkg::TRIG_LEVEL))    ? rawIn[i] :
         (trigSel[i] == 2'(irt_pkg::TRIG_ANY_EDGE)) ? (rise | fall) :
         (trigSel[i] == 2'(irt_pkg::TRIG_FALLING))  ? fall : rise;
   end

   // Set beats clear so an event in the clear cycle stays logged
   assign log_next = (log_reg & ~logClear) | hit | force_;

   // Bypass shows the live level and ignores log and trigger
   assign eventLog   = log_reg;
   assign activeView = (bypass & rawIn | ~bypass & log_reg) & enable;

   // Log and edge history
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         log_reg  <= '0;
         prev_reg <= '0;
      end else begin
         log_reg  <= log_next;
         prev_reg <= rawIn;
      end
   end
endmodule

// ************************************************************
// Top: router
// ************************************************************
module irt_router #(
   parameter int NUM_MOD = 8
) (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   // Interrupt sources
   input  wire logic [NUM_MOD-1:0]            portModuleIrq,
   input  wire logic [irt_pkg::NUM_EXT-1:0]   extSourceIn,
   input  wire irt_pkg::irt_periph_t          periphIrq,
   // Source configuration
   input  wire logic [irt_pkg::NUM_SRC-1:0][1:0] sourceTriggerSelect,
   input  wire logic [irt_pkg::NUM_SRC-1:0]   sourceStickyBypass,
   input  wire logic [irt_pkg::NUM_SRC-1:0]   sourceEventForce,
   input  wire logic [irt_pkg::NUM_SRC-1:0]   sourceLogClear,
   input  wire logic [irt_pkg::NUM_SRC-1:0]   sourceEnableClear,
   input  wire logic [irt_pkg::NUM_SRC-1:0]   sourceEnableSet,
   input  wire logic [irt_pkg::NUM_DST-1:0][irt_pkg::NUM_SRC-1:0]
                                              destinationSourceMask,
   // Module configuration
   input  wire logic [NUM_MOD-1:0]            moduleInputPolarity,
   input  wire logic [NUM_MOD-1:0][1:0]       moduleTriggerSelect,
   input  wire logic [NUM_MOD-1:0]            moduleStickyBypass,
   input  wire logic [NUM_MOD-1:0]            moduleLogClear,
   input  wire logic [NUM_MOD-1:0]            moduleEnableMask,
   // External pin configuration
   input  wire logic [irt_pkg::NUM_EXT-1:0]   extInputPolarity,
   input  wire logic [irt_pkg::NUM_EXT-1:0]   extOutputPolarity,
   input  wire logic [irt_pkg::NUM_EXT-1:0]   extOutputDriveMode,
   // Status views
   output logic [irt_pkg::NUM_SRC-1:0]        sourceRawView,
   output logic [irt_pkg::NUM_SRC-1:0]        sourceEventLog,
   output logic [irt_pkg::NUM_SRC-1:0]        sourceEnableMask,
   output logic [irt_pkg::NUM_SRC-1:0]        sourceActiveView,
   output logic [irt_pkg::NUM_DST-1:0][irt_pkg::NUM_SRC-1:0]
                                              destinationActiveView,
   output logic [NUM_MOD-1:0]                 moduleRawView,
   output logic [NUM_MOD-1:0]                 moduleEventLog,
   output logic [NUM_MOD-1:0]                 moduleActiveView,
   // Destinations
   output logic [1:0]                         cpuIrq,
   output irt_pkg::irt_pin_t [irt_pkg::NUM_EXT-1:0] extDestPin
);
   localparam int NS = irt_pkg::NUM_SRC;
   localparam int ND = irt_pkg::NUM_DST;

   logic [NUM_MOD-1:0] modRaw;
   logic [NUM_MOD-1:0] modLog;
   logic [NUM_MOD-1:0] modActive;
   logic [NS-1:0]      srcRaw;
   logic [NS-1:0]      srcLog;
   logic [NS-1:0]      srcActive;
   logic [NS-1:0]      ena_reg;
   logic [NS-1:0]      ena_next;
   logic [irt_pkg::NUM_EXT-1:0] extIn;
   logic [ND-1:0][NS-1:0] dstView;
   logic [ND-1:0]      dstLine;
   logic [irt_pkg::NUM_EXT-1:0] extLevel;
   logic [irt_pkg::NUM_EXT-1:0] extEnable;

   // Polarity correction makes every internal level active high
   assign modRaw = portModuleIrq ^ moduleInputPolarity;
   assign extIn  = extSourceIn ^ extInputPolarity;

   // Module hierarchy with the source control set minus force; enable is a plain mask
   irt_log_stage #(.W(NUM_MOD)) u_mod (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .rawIn      (modRaw),
      .trigSel    (moduleTriggerSelect),
      .bypass     (moduleStickyBypass),
      .force_     ('0),
      .logClear   (moduleLogClear),
      .enable     (moduleEnableMask),
      .eventLog   (modLog),
      .activeView (modActive)
   );

   // Source vector; one bit index throughout every view and mask
   assign srcRaw = {periphIrq,
                    extIn[1],
                    extIn[0],
                    |modActive};

   // Enable register with atomic clear and set; set listed last wins
   assign ena_next = (ena_reg & ~sourceEnableClear)
                     | sourceEnableSet;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ena_reg <= '0;
      end else begin
         ena_reg <= ena_next;
      end
   end

   // Source logging stage
   irt_log_stage #(.W(NS)) u_src (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .rawIn      (srcRaw),
      .trigSel    (sourceTriggerSelect),
      .bypass     (sourceStickyBypass),
      .force_     (sourceEventForce),
      .logClear   (sourceLogClear),
      .enable     (ena_reg),
      .eventLog   (srcLog),
      .activeView (srcActive)
   );

   // Destination masking, one lane per destination
   for (genvar d = 0; d < ND; d++) begin : g_dst
      assign dstView[d] = srcActive & destinationSourceMask[d];
      assign dstLine[d] = |dstView[d];
   end

   // Off-chip lines: polarity after the router; drive mode 1 emulates
   // open collector, enable only while asserting
   for (genvar e = 0; e < irt_pkg::NUM_EXT; e++) begin : g_ext
      assign extLevel[e]  = dstLine[irt_pkg::DST_EXT_ZERO + e]
                            ^ extOutputPolarity[e];
      assign extEnable[e] = ~extOutputDriveMode[e]
                            | dstLine[irt_pkg::DST_EXT_ZERO + e];
   end

   // All outputs registered; costs one cycle of latency
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sourceRawView         <= '0;
         sourceEventLog        <= '0;
         sourceEnableMask      <= '0;
         sourceActiveView      <= '0;
         destinationActiveView <= '0;
         moduleRawView         <= '0;
         moduleEventLog        <= '0;
         moduleActiveView      <= '0;
         cpuIrq                <= '0;
         extDestPin            <= '0;
      end else begin
         sourceRawView         <= srcRaw;
         sourceEventLog        <= srcLog;
         sourceEnableMask      <= ena_reg;
         sourceActiveView      <= srcActive;
         destinationActiveView <= dstView;
         moduleRawView         <= modRaw;
         moduleEventLog        <= modLog;
         moduleActiveView      <= modActive;
         cpuIrq                <= dstLine[irt_pkg::DST_CPU_ONE:
                                          irt_pkg::DST_CPU_ZERO];
         for (int e = 0; e < irt_pkg::NUM_EXT; e++) begin
            extDestPin[e] <= {extLevel[e], extEnable[e]};
         end
      end
   end
endmodule

/* File: irt_router_sva.sv */
// Checker: port-level properties of the interrupt router
`timescale 1ns/1ps
module irt_router_sva #(
   parameter int NUM_MOD = 8
) (
   // Clock and reset
   input wire logic                    clk_sys,
   input wire logic                    reset_n,
   // Inputs watched
   input wire logic [NUM_MOD-1:0]      portModuleIrq,
   input wire logic [NUM_MOD-1:0]      moduleInputPolarity,
   input wire logic [1:0]              extSourceIn,
   input wire logic [1:0]              extInputPolarity,
   input wire irt_pkg::irt_periph_t    periphIrq,
   input wire logic [25:0]             sourceEventForce,
   input wire logic [25:0]             sourceLogClear,
   input wire logic [25:0]             sourceEnableClear,
   input wire logic [25:0]             sourceEnableSet,
   input wire logic [25:0]             sourceStickyBypass,
   input wire logic [3:0][25:0]        destinationSourceMask,
   input wire logic [1:0]              extOutputPolarity,
   input wire logic [1:0]              extOutputDriveMode,
   // Outputs watched
   input wire logic [25:0]             sourceRawView,
   input wire logic [25:0]             sourceEventLog,
   input wire logic [25:0]             sourceEnableMask,
   input wire logic [25:0]             sourceActiveView,
   input wire logic [3:0][25:0]        destinationActiveView,
   input wire logic [NUM_MOD-1:0]      moduleRawView,
   input wire logic [1:0]              cpuIrq,
   input wire irt_pkg::irt_pin_t [1:0] extDestPin
);
   // ************************************************************
   // Helpers and properties
   // ************************************************************
   wire logic [1:0] extAct = {|destinationActiveView[3],
                              |destinationActiveView[2]};
   wire logic [1:0] pinEn = {extDestPin[1].enable, extDestPin[0].enable};
   wire logic [1:0] pinLv = {extDestPin[1].level, extDestPin[0].level};

   // One domain, so clock and reset are given once
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_raw_periph_map: assert property (
      $past(reset_n) |->
      sourceRawView[25:3] == $past(periphIrq)) else $error("raw periph");
   a_raw_ext_pol: assert property ($past(reset_n) |->
      sourceRawView[2:1] == $past(extSourceIn ^ extInputPolarity))
      else $error("raw ext");
   a_mod_raw_pol: assert property ($past(reset_n) |->
      moduleRawView == $past(portModuleIrq ^ moduleInputPolarity))
      else $error("module raw");
   a_reset_quiet: assert property (!$past(reset_n) |->
      {cpuIrq, sourceEventLog, sourceEnableMask} == '0) else $error("reset");
   // Enable and log sit two flops behind their inputs at the ports
   a_enable_set_clear: assert property (
      $past(reset_n) && $past(reset_n, 2) |-> sourceEnableMask ==
      ($past(sourceEnableMask) & ~$past(sourceEnableClear, 2)
      | $past(sourceEnableSet, 2))) else $error("enable update");
   a_log_holds: assert property (
      $past(reset_n) && $past(reset_n, 2) |-> (~sourceEventLog &
      $past(sourceEventLog) & ~$past(sourceLogClear, 2)) == '0)
      else $error("log lost");
   a_force_logs: assert property (
      $past(reset_n) && $past(reset_n, 2) |->
      (~sourceEventLog & $past(sourceEventForce, 2)) == '0)
      else $error("force");
   a_active_view: assert property (sourceStickyBypass == '0 &&
      $past(sourceStickyBypass) == '0 |->
      sourceActiveView == (sourceEventLog & sourceEnableMask))
      else $error("active view");
   a_dest_view: assert property (
      destinationActiveView ==
      ({4{sourceActiveView}} & $past(destinationSourceMask)))
      else $error("dest view");
   a_cpu_lines: assert property (cpuIrq ==
      {|destinationActiveView[1], |destinationActiveView[0]})
      else $error("cpu line");
   a_ext_out_pin: assert property ($past(reset_n) &&
      $stable(extOutputDriveMode) && $stable(extOutputPolarity) |->
      pinEn == (~extOutputDriveMode | extAct)
      && ((pinLv ^ extAct ^ extOutputPolarity) & pinEn) == 2'h0)
      else $error("ext pin");

   c_cpu_raise: cover property ($rose(cpuIrq[0]));
   c_force: cover property (sourceEventForce != '0);
   c_released: cover property (extOutputDriveMode != 2'h0 && pinEn == 2'h0);
endmodule

bind irt_router irt_router_sva #(.NUM_MOD(NUM_MOD)) irt_router_sva_i (.*);

/* File: irt_pin_model.sv */
// Partner model: external interrupt pins outside the device
`timescale 1ns/1ps
module irt_pin_model (
   // Source pins: request and board wiring polarity
   input  wire logic [1:0]              req,
   input  wire logic [1:0]              activeLow,
   output wire logic [1:0]              srcPin,
   // Destination pins with a board pull-up
   input  wire irt_pkg::irt_pin_t [1:0] dstPin,
   output wire logic [1:0]              dstWire
);
   // Active-low wiring pulls the pin down while requesting
   assign srcPin = req ^ activeLow;
   // A released pin floats to the pull-up, never holds its last value
   assign dstWire[0] = dstPin[0].enable ? dstPin[0].level : 1'h1;
   assign dstWire[1] = dstPin[1].enable ? dstPin[1].level : 1'h1;
endmodule

/* File: tb.sv */
// Testbench: table rows and directed cases for the interrupt router
`timescale 1ns/1ps
module tb;
   // ************************************************************
   // Signals, instances and tasks
   // ************************************************************
   logic                       clk_sys = 1'h0;
   logic                       reset_n = 1'h0;
   logic [7:0]                 portModuleIrq = 8'h00;
   logic [1:0]                 extSourceIn, extReq = 2'h0, pinWire;
   irt_pkg::irt_periph_t       periphIrq = '0;
   logic [25:0][1:0]           sourceTriggerSelect = '0;
   logic [25:0]                sourceStickyBypass = '0, sourceEventForce = '0;
   logic [25:0]                sourceLogClear = '0, sourceEnableClear = '0;
   logic [25:0]                sourceEnableSet = '0;
   logic [3:0][25:0]           destinationSourceMask = '0;
   logic [7:0]                 moduleInputPolarity = 8'h00;
   logic [7:0][1:0]            moduleTriggerSelect = '0;
   logic [7:0]                 moduleStickyBypass = 8'h00;
   logic [7:0]                 moduleLogClear = 8'h00;
   logic [7:0]                 moduleEnableMask = 8'h00;
   logic [1:0]                 extInputPolarity = 2'h0;
   logic [1:0]                 extOutputPolarity = 2'h0;
   logic [1:0]                 extOutputDriveMode = 2'h0;
   logic [25:0]                sourceRawView, sourceEventLog;
   logic [25:0]                sourceEnableMask, sourceActiveView;
   logic [3:0][25:0]           destinationActiveView;
   logic [7:0]                 moduleRawView, moduleEventLog, moduleActiveView;
   logic [1:0]                 cpuIrq;
   irt_pkg::irt_pin_t [1:0]    extDestPin;
   // Rows: trigger, level before, level after, expected log
   logic [4:0]                 rows [8] = '{5'h03, 5'h00, 5'h0B, 5'h0D,
                                            5'h12, 5'h15, 5'h1C, 5'h1B};
   int                         errTotal = 0;
   int                         checkCount = 0;
   int                         cycles = 0;

   irt_router irt_router_i (.*);
   irt_pin_model irt_pin_model_i (.req(extReq), .activeLow(extInputPolarity),
      .srcPin(extSourceIn), .dstPin(extDestPin), .dstWire(pinWire));

   always #2 clk_sys = ~clk_sys;

   // Cycle ceiling cuts a hang short
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         errTotal++;
         $display("mismatch at %0t: timeout", $time);
         stopTest();
      end
   end

   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Checks happen mid-cycle so clock-edge updates have landed
   task automatic look;
      @(negedge clk_sys);
   endtask

   task automatic chk(input logic [25:0] g, input logic [25:0] e);
      checkCount++;
      if (g !== e) begin
         errTotal++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic stopTest;
      $display("checks %0d mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      w(12);
      reset_n <= 1'h1;
      w(2);
      look;
      chk(sourceEventLog | sourceEnableMask, 26'h0);
      chk({24'h0, cpuIrq}, 26'h0);
      $display("end reset");
      w(1);
      sourceEnableSet <= 26'h3FFFFFF;
      destinationSourceMask <= {26'h0888888, 26'h0444444, 26'h2222222,
                                26'h1111111};
      w(1);
      sourceEnableSet <= 26'h0;
      sourceEnableClear <= 26'h00000F0;
      w(1);
      sourceEnableClear <= 26'h0;
      w(2);
      look;
      chk(sourceEnableMask, 26'h3FFFF0F);
      w(1);
      sourceEnableSet <= 26'h00000F0;
      w(1);
      sourceEnableSet <= 26'h0;
      w(2);
      look;
      chk(sourceEnableMask, 26'h3FFFFFF);
      $display("end enables");
      // Every trigger mode on source bit 3, routed to pin one
      for (int r = 0; r < 8; r++) begin
         w(1);
         sourceTriggerSelect[3] <= rows[r][4:3];
         periphIrq.timerZeroIrq <= rows[r][2];
         w(4);
         sourceLogClear <= 26'h0000008;
         w(1);
         sourceLogClear <= 26'h0;
         w(4);
         periphIrq.timerZeroIrq <= rows[r][1];
         w(4);
         look;
         chk({25'h0, sourceEventLog[3]}, {25'h0, rows[r][0]});
         chk({24'h0, pinWire}, {24'h0, rows[r][0], 1'h0});
      end
      $display("end trigger rows");
      // Each peripheral bit in turn, to the destination k mod 4
      for (int k = 3; k < 26; k++) begin
         w(1);
         periphIrq <= irt_pkg::irt_periph_t'(23'h1 << (k - 3));
         w(1);
         periphIrq <= '0;
         w(3);
         look;
         chk(sourceActiveView, 26'h1 << k);
         chk({22'h0, pinWire, cpuIrq}, 26'h1 << (k % 4));
         chk(destinationActiveView[k % 4], 26'h1 << k);
         w(1);
         sourceLogClear <= 26'h1 << k;
         w(1);
         sourceLogClear <= 26'h0;
         w(3);
         look;
         chk(sourceEventLog, 26'h0);
      end
      $display("end routing");
      w(1);
      sourceEventForce <= 26'h0000800;
      w(1);
      sourceEventForce <= 26'h0;
      periphIrq.timerOneIrq <= 1'h1;
      w(3);
      look;
      chk(sourceEventLog, 26'h0000810);
      w(1);
      sourceLogClear <= 26'h0000810;
      w(1);
      sourceLogClear <= 26'h0;
      sourceStickyBypass <= 26'h0000010;
      periphIrq <= '0;
      w(4);
      look;
      chk(sourceEventLog ^ sourceActiveView, 26'h0000010);
      w(1);
      sourceStickyBypass <= 26'h0;
      sourceLogClear <= 26'h0000010;
      moduleInputPolarity <= 8'h04;
      w(1);
      sourceLogClear <= 26'h0;
      w(5);
      look;
      chk({18'h0, moduleRawView}, 26'h4);
      chk({18'h0, moduleEventLog}, 26'h4);
      chk(sourceRawView, 26'h0);
      w(1);
      moduleEnableMask <= 8'h04;
      w(5);
      look;
      chk({24'h0, cpuIrq}, 26'h1);
      chk({18'h0, moduleActiveView}, 26'h4);
      w(1);
      moduleInputPolarity <= 8'h00;
      moduleLogClear <= 8'h04;
      w(1);
      moduleLogClear <= 8'h00;
      w(4);
      sourceLogClear <= 26'h1;
      w(1);
      sourceLogClear <= 26'h0;
      w(4);
      look;
      chk({24'h0, cpuIrq}, 26'h0);
      $display("end module path");
      w(1);
      extInputPolarity <= 2'h1;
      extReq <= 2'h1;
      w(4);
      look;
      chk(sourceRawView, 26'h2);
      w(1);
      extReq <= 2'h0;
      extOutputDriveMode <= 2'h3;
      w(3);
      look;
      chk({22'h0, extDestPin}, 26'h0);
      chk({24'h0, pinWire}, 26'h3);
      w(1);
      extOutputDriveMode <= 2'h0;
      extOutputPolarity <= 2'h3;
      w(3);
      look;
      chk({22'h0, extDestPin}, 26'hF);
      $display("end external pins");
      stopTest();
   end
endmodule
